// ### rcl_pkg.sv
/*
  Package for the reset configuration loader: option layouts, reset
  values, load sequencing constants and the carrier structs.
  Assumes a single 25 MHz bus clock domain.
*/
`default_nettype none
package rcl_pkg;

  localparam int unsigned CLK_HZ        = 25_000_000;
  // Flash clock divider value forced by the debug mass erase
  localparam logic [7:0]  FDIV_ERASE    = 8'h05;
  localparam logic [7:0]  FDIV_RST      = 8'h00;
  // Field positions inside the flash option byte
  localparam int unsigned OPT_RATE_LSB  = 0;
  localparam int unsigned OPT_RATE_W    = 3;
  localparam int unsigned OPT_WIN_POS   = 3;
  // Watchdog reset values before the load completes
  localparam logic [2:0]  RATE_RST      = 3'h0;
  localparam logic        WIN_RST       = 1'b0;
  // Words loaded from flash during the reset sequence
  localparam int unsigned LOAD_WORDS    = 4;
  // Index of the word holding the option byte
  localparam int unsigned OPT_WORD_IDX  = 3;

  typedef enum logic {
    RCL_RST_WARM,
    RCL_RST_POR
  } rcl_rst_kind_t;

  // Watchdog settings handed to the clock and watchdog unit
  typedef struct packed {
    logic [2:0] cop_rate_field;
    logic       window_mode_bit;
  } rcl_wdog_t;

  // One flash read answer
  typedef struct packed {
    logic [7:0] data;
    logic       dbl_fault;
  } rcl_rdata_t;

endpackage
`default_nettype wire

// ### rcl_ram_init.sv
/*
  System RAM initialiser: walks every address of the system RAM and
  writes zero data with matching syndrome after a power-on reset.
  Assumes the RAM accepts one write per clock while wr_o is high.
*/
`timescale 1ns/100ps
`default_nettype none
module rcl_ram_init
  import rcl_pkg::*;
#(
  parameter int unsigned ADDR_W = 10
) (
  input  wire logic              sys_clk_i,
  input  wire logic              reset_i,
  input  wire logic              start_i,
  output logic                   busy_o,
  output logic                   wr_o,
  output logic [ADDR_W-1:0]      addr_o
);

  // Refuse address widths the walker cannot serve
  if (ADDR_W < 1 || ADDR_W > 24) begin : g_bad_addr_w
    $error("rcl_ram_init: ADDR_W out of range");
  end

  // Address walker; zero data carries a zero syndrome
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      busy_o <= 1'b0;
      wr_o   <= 1'b0;
      addr_o <= '0;
    end else if (start_i && !busy_o) begin
      busy_o <= 1'b1;
      wr_o   <= 1'b1;
      addr_o <= '0;
    end else if (busy_o) begin
      if (addr_o == {ADDR_W{1'b1}}) begin
        busy_o <= 1'b0;
        wr_o   <= 1'b0;
      end else begin
        addr_o <= addr_o + 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

// ### rcl_loader.sv
/*
  Reset configuration loader: holds the CPU after every reset while
  flash configuration words are read, loads the watchdog settings,
  aborts a running flash command, sequences system RAM initialisation
  after power-on and forces the flash clock divider on debug erase.
  Assumes the flash answers each read with rd_valid_i some cycles later.
*/
// Notes on behaviour
// - Every reset holds the CPU until all configuration words load.
// - A double fault during load leaves protection and security on.
// - Any reset aborts a running program or erase at once.
// - System RAM and syndromes are initialised on power-on only.
// - No other RAM is ever initialised by any reset.
// - Only low-voltage resets may disturb stored RAM contents.
// - Watchdog rate and window bits load from the option byte.
// - The loaded rate is the bitwise inverse of the option bits.
// - The loaded window bit is the inverse of option bit three.
// - The mass-erase request follows the debug erase request.
// - Debug mass erase forces the flash clock divider to 0x05.
// - Any reset sets defaults; some clock regs need power-on.
`timescale 1ns/100ps
`default_nettype none
module rcl_loader
  import rcl_pkg::*;
#(
  parameter int unsigned RAM_ADDR_W = 10,
  parameter int unsigned N_WORDS    = LOAD_WORDS
) (
  input  wire logic                  sys_clk_i,
  input  wire logic                  reset_i,
  input  wire rcl_rst_kind_t         rst_kind_i,
  input  wire logic                  low_voltage_rst_i,
  output logic                       cpu_hold_o,
  output logic                       rd_req_o,
  output logic [7:0]                 rd_idx_o,
  input  wire logic                  rd_valid_i,
  input  wire rcl_rdata_t            rd_data_i,
  output logic                       prot_force_o,
  output logic                       cmd_abort_o,
  input  wire logic                  cmd_active_i,
  output rcl_wdog_t                  wdog_o,
  input  wire logic                  wdog_wr_i,
  input  wire rcl_wdog_t             wdog_wdata_i,
  output logic                       ram_wr_o,
  output logic [RAM_ADDR_W-1:0]      ram_addr_o,
  output logic                       other_ram_init_o,
  output logic                       ram_scrub_allow_o,
  output logic                       por_only_rst_o,
  input  wire logic                  dbg_erase_req_i,
  output logic                       mass_erase_req_o,
  output logic [7:0]                 flash_clock_divider_o,
  input  wire logic                  fdiv_wr_i,
  input  wire logic [7:0]            fdiv_wdata_i
);

  // Refuse word counts that cannot reach the option word
  if (N_WORDS < 1 || N_WORDS > 255 ||
      OPT_WORD_IDX >= N_WORDS) begin : g_bad_words
    $error("rcl_loader: N_WORDS cannot hold the option word");
  end

  typedef enum logic [1:0] {
    ST_ISSUE,
    ST_WAIT,
    ST_RAM,
    ST_DONE
  } rcl_state_t;

  rcl_state_t  state;
  logic [7:0]  word_idx;
  logic        is_por;
  logic        ram_busy;
  logic        ram_start;
  logic        last_word;

  assign last_word = (word_idx == 8'(N_WORDS - 1));

  // Reset kind captured on a clocked edge, never from async reset
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      is_por <= (rst_kind_i == RCL_RST_POR);
    end
  end

  // Load sequencer
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      state    <= ST_ISSUE;
      word_idx <= 8'h00;
    end else begin
      unique case (state)
        ST_ISSUE: state <= ST_WAIT;
        ST_WAIT: begin
          if (rd_valid_i) begin
            if (last_word) begin
              state <= is_por ? ST_RAM : ST_DONE;
            end else begin
              word_idx <= word_idx + 8'h01;
              state    <= ST_ISSUE;
            end
          end
        end
        ST_RAM: begin
          if (!ram_busy && !ram_start) begin
            state <= ST_DONE;
          end
        end
        ST_DONE: state <= ST_DONE;
      endcase
    end
  end

  assign cpu_hold_o = (state != ST_DONE);
  assign rd_req_o   = (state == ST_ISSUE);
  assign rd_idx_o   = word_idx;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      ram_start <= 1'b0;
    end else begin
      ram_start <= (state == ST_WAIT) && rd_valid_i && last_word && is_por;
    end
  end

  rcl_ram_init #(
    .ADDR_W (RAM_ADDR_W)
  ) u_ram_init (
    .sys_clk_i (sys_clk_i),
    .reset_i   (reset_i),
    .start_i   (ram_start),
    .busy_o    (ram_busy),
    .wr_o      (ram_wr_o),
    .addr_o    (ram_addr_o)
  );

  assign other_ram_init_o  = 1'b0;
  assign ram_scrub_allow_o = low_voltage_rst_i;
  assign por_only_rst_o    = reset_i && (rst_kind_i == RCL_RST_POR);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      prot_force_o <= 1'b0;
    end else if (state == ST_WAIT && rd_valid_i && rd_data_i.dbl_fault) begin
      prot_force_o <= 1'b1;
    end
  end

  assign cmd_abort_o = reset_i && cmd_active_i;

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      wdog_o.cop_rate_field  <= RATE_RST;
      wdog_o.window_mode_bit <= WIN_RST;
    end else if (state == ST_WAIT && rd_valid_i &&
                 word_idx == 8'(OPT_WORD_IDX)) begin
      wdog_o.cop_rate_field  <=
        ~rd_data_i.data[OPT_RATE_LSB +: OPT_RATE_W];
      wdog_o.window_mode_bit <= ~rd_data_i.data[OPT_WIN_POS];
    end else if (wdog_wr_i && state == ST_DONE) begin
      wdog_o <= wdog_wdata_i;
    end
  end

  assign mass_erase_req_o = dbg_erase_req_i;

  // Erase force wins over a software write in the same cycle
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      flash_clock_divider_o <= FDIV_RST;
    end else if (dbg_erase_req_i) begin
      flash_clock_divider_o <= FDIV_ERASE;
    end else if (fdiv_wr_i) begin
      flash_clock_divider_o <= fdiv_wdata_i;
    end
  end

  property p_hold_during_load;
    @(posedge sys_clk_i) disable iff (reset_i)
    !cpu_hold_o |-> (word_idx == 8'(N_WORDS - 1)) && !ram_busy;
  endproperty
  a_hold_during_load: assert property (p_hold_during_load)
    else $error("cpu released before load done");

  property p_prot_sticky;
    @(posedge sys_clk_i) disable iff (reset_i)
    prot_force_o |=> prot_force_o;
  endproperty
  a_prot_sticky: assert property (p_prot_sticky)
    else $error("protection force dropped");

  property p_warm_no_ram;
    @(posedge sys_clk_i) disable iff (reset_i)
    !is_por |-> !ram_wr_o;
  endproperty
  a_warm_no_ram: assert property (p_warm_no_ram)
    else $error("RAM written after warm reset");

  sequence s_opt_load;
    state == ST_WAIT && rd_valid_i && word_idx == 8'(OPT_WORD_IDX);
  endsequence
  property p_rate_inv;
    @(posedge sys_clk_i) disable iff (reset_i)
    s_opt_load |=> wdog_o.cop_rate_field ==
      ~$past(rd_data_i.data[OPT_RATE_LSB +: OPT_RATE_W]);
  endproperty
  a_rate_inv: assert property (p_rate_inv)
    else $error("rate not inverse of option");

  property p_win_inv;
    @(posedge sys_clk_i) disable iff (reset_i)
    s_opt_load |=> wdog_o.window_mode_bit !=
      $past(rd_data_i.data[OPT_WIN_POS]);
  endproperty
  a_win_inv: assert property (p_win_inv)
    else $error("window not inverse of option");

  property p_fdiv_force;
    @(posedge sys_clk_i) disable iff (reset_i)
    dbg_erase_req_i |=> flash_clock_divider_o == FDIV_ERASE;
  endproperty
  a_fdiv_force: assert property (p_fdiv_force)
    else $error("divider not forced on erase");

  property p_wdog_hold;
    @(posedge sys_clk_i) disable iff (reset_i)
    (state == ST_DONE && !wdog_wr_i) |=> $stable(wdog_o);
  endproperty
  a_wdog_hold: assert property (p_wdog_hold)
    else $error("watchdog bits changed without write");

  property p_release;
    @(posedge sys_clk_i) disable iff (reset_i)
    (state == ST_WAIT && rd_valid_i && last_word && !is_por)
      |=> !cpu_hold_o;
  endproperty
  a_release: assert property (p_release)
    else $error("cpu not released after warm load");

endmodule
`default_nettype wire

// ### rcl_flash_model.sv
/*
  Far-side model: flash array answering configuration reads.
  Assumes the loader's clock and reset, one read outstanding.
*/
`timescale 1ns/100ps
`default_nettype none
module rcl_flash_model
  import rcl_pkg::*;
(
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  input  wire logic       rd_req_i,
  input  wire logic [7:0] rd_idx_i,
  input  wire logic       slow_i,
  input  wire logic [3:0] opt_i,
  input  wire logic       fault_i,
  output logic            rd_valid_o,
  output rcl_rdata_t      rd_data_o
);
  logic       busy;
  logic [2:0] cnt;
  rcl_rdata_t last;
  // Released lines show the inverse, never a stale copy
  assign rd_data_o = rd_valid_o ? last : ~last;
  // Take one read, answer after 1 or 5 cycles
  always_ff @(posedge sys_clk_i) begin
    rd_valid_o <= 1'b0;
    if (reset_i) begin
      busy <= 1'b0;
      last <= '0;
    end else if (!busy && rd_req_i) begin
      busy <= 1'b1;
      cnt  <= slow_i ? 3'h4 : 3'h0;
    end else if (busy && cnt != 3'h0) begin
      cnt <= cnt - 3'h1;
    end else if (busy) begin
      busy       <= 1'b0;
      rd_valid_o <= 1'b1;
      last.data  <= (rd_idx_i == 8'h03) ? {4'h0, opt_i} : rd_idx_i;
      last.dbl_fault <= fault_i;
    end
  end
endmodule
`default_nettype wire

// ### reset_config_loader_tb.sv
/*
  Self-checking bench for the reset configuration loader.
  Assumes the flash model file; RAM walk shortened to 8 words.
*/
`timescale 1ns/100ps
`default_nettype none
module reset_config_loader_tb;
  import rcl_pkg::*;
  logic sys_clk_i, reset_i = 1, low_voltage_rst_i = 0, cmd_active_i = 0;
  // Write stands through the first power-on hold and RAM walk
  logic wdog_wr_i = 1, dbg_erase_req_i = 0, fdiv_wr_i = 0;
  logic slow = 0, fault = 0, rd_valid_i;
  logic [3:0] opt = 4'h0;
  logic [7:0] fdiv_wdata_i = 8'h00;
  rcl_rst_kind_t rst_kind_i = RCL_RST_POR;
  rcl_wdog_t     wdog_wdata_i = '0;
  rcl_wdog_t     wdog_o;
  rcl_rdata_t    rd_data_i;
  logic cpu_hold_o, rd_req_o, prot_force_o, cmd_abort_o, ram_wr_o;
  logic other_ram_init_o, ram_scrub_allow_o, por_only_rst_o;
  logic mass_erase_req_o;
  logic [7:0] rd_idx_o, flash_clock_divider_o;
  logic [2:0] ram_addr_o;
  int failures = 0, checks = 0, wr_cnt;
  // Option nibble beside expected watchdog bits
  logic [7:0] rows [7] = '{8'h0F, 8'h1D, 8'h71, 8'h8E, 8'hF0, 8'h47, 8'hAA};

  rcl_loader #(.RAM_ADDR_W(3)) dut (.sys_clk_i, .reset_i, .rst_kind_i,
    .low_voltage_rst_i, .cpu_hold_o, .rd_req_o, .rd_idx_o, .rd_valid_i,
    .rd_data_i, .prot_force_o, .cmd_abort_o, .cmd_active_i, .wdog_o,
    .wdog_wr_i, .wdog_wdata_i, .ram_wr_o, .ram_addr_o, .other_ram_init_o,
    .ram_scrub_allow_o, .por_only_rst_o, .dbg_erase_req_i,
    .mass_erase_req_o, .flash_clock_divider_o, .fdiv_wr_i, .fdiv_wdata_i);
  rcl_flash_model fm (.sys_clk_i, .reset_i, .rd_req_i(rd_req_o),
    .rd_idx_i(rd_idx_o), .slow_i(slow), .opt_i(opt), .fault_i(fault),
    .rd_valid_o(rd_valid_i), .rd_data_o(rd_data_i));

  initial begin
    sys_clk_i = 0;
    forever #20 sys_clk_i = ~sys_clk_i;
  end

  task chk(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask

  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task do_reset(input rcl_rst_kind_t k);
    @(negedge sys_clk_i);
    reset_i = 1;
    rst_kind_i = k;
    repeat (4) @(negedge sys_clk_i);
    reset_i = 0;
  endtask

  // Reset, then count RAM writes while the CPU is held
  task boot(input rcl_rst_kind_t k);
    int n;
    do_reset(k);
    wr_cnt = 0;
    n = 0;
    while (cpu_hold_o === 1'b1 && n < 300) begin
      @(posedge sys_clk_i);
      #1;
      if (ram_wr_o === 1'b1) begin
        chk(ram_addr_o, 8'(wr_cnt), "ram address walk");
        wr_cnt++;
      end
      n++;
    end
    if (n >= 300) begin
      failures++;
      give_verdict();
    end
  endtask

  // Hang guard, well past the expected run
  initial begin
    #(40 * 20000);
    failures++;
    give_verdict();
  end

  initial begin
    boot(RCL_RST_POR);
    chk(wr_cnt, 8, "ram walk on power-on");
    chk(other_ram_init_o, 0, "other ram init");
    chk(wdog_o, 8'h0F, "watchdog after power-on");
    chk(rd_idx_o, 8'(LOAD_WORDS - 1), "last word index");
    chk(rd_req_o, 0, "no read after load");
    // Software writes during the hold must be ignored
    foreach (rows[i]) begin
      @(negedge sys_clk_i);
      opt = rows[i][7:4];
      slow = i[0];
      wdog_wr_i = 1;
      boot(RCL_RST_WARM);
      chk(wr_cnt, 0, "ram walk on warm");
      chk(wdog_o, rows[i][3:0], "loaded watchdog bits");
      @(negedge sys_clk_i);
      wdog_wr_i = 0;
    end
    repeat (5) @(negedge sys_clk_i);
    chk(wdog_o, 8'h0A, "watchdog held");
    wdog_wdata_i = 4'h5;
    wdog_wr_i = 1;
    @(negedge sys_clk_i);
    wdog_wr_i = 0;
    chk(wdog_o, 8'h05, "watchdog write");
    // Reset with a command running
    cmd_active_i = 1;
    #1 chk(cmd_abort_o, 0, "abort without reset");
    @(negedge sys_clk_i);
    reset_i = 1;
    #1 chk(cmd_abort_o, 1, "abort on reset");
    chk(por_only_rst_o, 0, "warm kind");
    @(negedge sys_clk_i);
    rst_kind_i = RCL_RST_POR;
    #1 chk(por_only_rst_o, 1, "power-on kind");
    chk(cpu_hold_o, 1, "hold in reset");
    chk(wdog_o, 8'h00, "watchdog reset value");
    cmd_active_i = 0;
    fault = 1;
    boot(RCL_RST_WARM);
    chk(prot_force_o, 1, "double fault");
    fault = 0;
    boot(RCL_RST_WARM);
    chk(prot_force_o, 0, "clean load");
    @(negedge sys_clk_i);
    low_voltage_rst_i = 1;
    #1 chk(ram_scrub_allow_o, 1, "low voltage");
    @(negedge sys_clk_i);
    low_voltage_rst_i = 0;
    #1 chk(ram_scrub_allow_o, 0, "no low voltage");
    @(negedge sys_clk_i);
    fdiv_wdata_i = 8'h33;
    fdiv_wr_i = 1;
    dbg_erase_req_i = 1;
    #1 chk(mass_erase_req_o, 1, "erase request");
    @(negedge sys_clk_i);
    chk(flash_clock_divider_o, FDIV_ERASE, "erase divider");
    dbg_erase_req_i = 0;
    #1 chk(mass_erase_req_o, 0, "erase released");
    @(negedge sys_clk_i);
    fdiv_wr_i = 0;
    chk(flash_clock_divider_o, 8'h33, "divider write");
    do_reset(RCL_RST_WARM);
    chk(flash_clock_divider_o, FDIV_RST, "divider reset");
    give_verdict();
  end
endmodule
`default_nettype wire
